// ### rtl/rcss_pkg.sv
/*
 package for the reset and clock start-up sequencer: delay figures,
 derived cycle counts, clock source and reset cause encodings, register map.
 assumes the sequencer runs from a 50 MHz reference clock.
*/
package rcss_pkg;

	localparam int CLK_HZ = 50000000;
	// delay figures in their own unit
	localparam int POR_DELAY_NS = 10000;
	localparam int STARTUP_REG_NS = 20000;
	localparam int POWER_UP_TIMER_MS = 64;
	localparam int RST_DELAY_NS = 20000;
	localparam int LOCK_NS = 20000;
	localparam int MON_DELAY_US = 500;
	// derived cycle counts, 20 ns period
	localparam int CLK_NS = 1000000000 / CLK_HZ;
	localparam int POR_CYC = POR_DELAY_NS / CLK_NS;
	localparam int STARTUP_REG_CYC = STARTUP_REG_NS / CLK_NS;
	localparam int POWER_UP_TIMER_CYC = (POWER_UP_TIMER_MS * 1000000) / CLK_NS;
	localparam int RST_CYC = RST_DELAY_NS / CLK_NS;
	localparam int LOCK_CYC = LOCK_NS / CLK_NS;
	localparam int MON_CYC = (MON_DELAY_US * 1000) / CLK_NS;
	localparam int OST_BITS = 10;
	localparam int CNT_W = 24;

	// clock source selection from the oscillator config word
	typedef enum logic [2:0] {
		SRC_EXT = 3'h0,
		SRC_FRC = 3'h1,
		SRC_INTERNAL_LOW_POWER_RC_OSC = 3'h2,
		SRC_EXT_PLL = 3'h3,
		SRC_FRC_PLL = 3'h4,
		SRC_XTAL = 3'h5,
		SRC_XTAL_PLL = 3'h6
	} rcss_src_e;

	// reset cause bit positions
	localparam int CAUSE_W = 7;
	localparam int CB_POR = 0;
	localparam int CB_PIN = 1;
	localparam int CB_WDOG = 2;
	localparam int CB_SW = 3;
	localparam int CB_OPC = 4;
	localparam int CB_UNINIT = 5;
	localparam int CB_TRAP = 6;

	// register map, word indices
	localparam logic [3:0] ADDR_CAUSE = 4'h0;
	localparam logic [3:0] ADDR_OSC = 4'h1;
	localparam logic [3:0] ADDR_STAT = 4'h2;
	localparam logic [3:0] ADDR_IRQ = 4'h3;
	localparam logic [3:0] ADDR_MASK = 4'h4;
	localparam logic [3:0] ADDR_CTRL = 4'h5;
	// event bits
	localparam int EV_W = 3;
	localparam int EV_RUN = 0;
	localparam int EV_CLKFAIL = 1;
	localparam int EV_MONON = 2;
	localparam logic [EV_W-1:0] MASK_RST = 3'h0;

endpackage

// ### rtl/rcss_sequencer.sv
/*
 reset and clock start-up sequencer: holds the system reset, waits for a
 valid clock, arms the clock monitor, keeps the reset cause and oscillator
 state, and offers a small register port with an interrupt.
 assumes all inputs are synchronous to mclk and reset is the power-on reset.
*/
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Operation
// - power-on holds system reset through power-on, start-up, then internal reset.
// - crystal waits start-up timer, pll waits lock, crystal pll waits both.
// - pin, watchdog, software and fault resets apply only internal reset time.
// - power-on delay lasts about ten microseconds.
// - start-up delay short with regulator on, long power-up timer otherwise.
// - wake from power-down applies start-up delay only when regulator is on.
// - ten-bit start-up timer counts 1024 oscillator periods before clock release.
// - pll source waits a lock interval before its clock is available.
// - crystal or pll sources insert monitor delay before monitoring starts.
// - enabled monitor starts checking when reset releases, after any delay.
// - no valid clock at monitor start switches to fast rc and traps.
// - core does not run until a valid clock is released.
// - clock start-up timing runs independently of reset delay timers.
// - other registers reset alike regardless of reset type; here warm resets keep the event and mask bits, only power-on clears them.
// - cause register records reset type; oscillator register reflects type and config.
// - monitor delay nominally 500 us, kept as a parameter.
module rcss_sequencer
	import rcss_pkg::*;
#(
	parameter int PORC = POR_CYC,
	parameter int STARTC = STARTUP_REG_CYC,
	parameter int PWRTC = POWER_UP_TIMER_CYC,
	parameter int RSTC = RST_CYC,
	parameter int LOCKC = LOCK_CYC,
	parameter int MONC = MON_CYC
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic extResetPinReq,
	input wire logic watchdogReq,
	input wire logic softwareReq,
	input wire logic illegalOpcodeReq,
	input wire logic uninitRegReq,
	input wire logic trapConflictReq,
	input wire logic wakeReq,
	input wire logic regulatorEn,
	input wire logic [2:0] oscConfigWord,
	input wire logic monitorEn,
	input wire logic oscTick,
	input wire logic pllLocked,
	input wire logic clockValid,
	input wire logic [3:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdata,
	output logic systemResetSignal,
	output logic coreRun,
	output logic monitorActive,
	output logic useFastRc,
	output logic trapReq,
	output logic irq
);

	typedef enum logic [2:0] {
		ST_POR = 3'h0,
		ST_START = 3'h1,
		ST_RST = 3'h2,
		ST_DONE = 3'h3
	} rcss_rst_e;

	typedef enum logic [1:0] {
		CK_OST = 2'h0,
		CK_LOCK = 2'h1,
		CK_OK = 2'h2
	} rcss_clk_e;

	typedef struct packed {
		rcss_rst_e rst;
		logic [CNT_W-1:0] rcnt;
		rcss_clk_e ck;
		logic [OST_BITS-1:0] ost;
		logic [CNT_W-1:0] kcnt;
		logic monWait;
		logic [CNT_W-1:0] mcnt;
		logic monOn;
		logic fastRc;
		logic trap;
		logic [CAUSE_W-1:0] cause;
		rcss_src_e src;
		logic [EV_W-1:0] evt;
		logic [EV_W-1:0] mask;
		logic [15:0] rdata;
		logic runQ;
	} rcss_state_s;

	// state after power-on: only the power-on cause bit is set
	localparam rcss_state_s ST_INIT = '{
		rst: ST_POR,
		rcnt: '0,
		ck: CK_OST,
		ost: '0,
		kcnt: '0,
		monWait: 1'b1,
		mcnt: '0,
		monOn: 1'b0,
		fastRc: 1'b0,
		trap: 1'b0,
		cause: CAUSE_W'(1),
		src: SRC_EXT,
		evt: '0,
		mask: MASK_RST,
		rdata: '0,
		runQ: 1'b0
	};

	rcss_state_s st_r;
	rcss_state_s st_nxt;

	logic [CAUSE_W-1:0] warmReq;
	logic hasPll;
	logic hasXtal;
	logic clkLong;
	logic [EV_W-1:0] evSet;
	// config word is captured on the first edge after power-on release
	logic cfgTaken_r;
	rcss_src_e srcNow;

	// bit 0 stays clear: power-on is not a warm request
	assign warmReq = {
		trapConflictReq,
		uninitRegReq,
		illegalOpcodeReq,
		softwareReq,
		watchdogReq,
		extResetPinReq,
		1'b0
	};

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		evSet = '0;
		// source must be known on the first edge, or the monitor delay is lost
		srcNow = cfgTaken_r ? st_r.src : rcss_src_e'(oscConfigWord);
		st_nxt.src = srcNow;
		hasPll = (srcNow == SRC_EXT_PLL) || (srcNow == SRC_FRC_PLL) ||
			(srcNow == SRC_XTAL_PLL);
		hasXtal = (srcNow == SRC_XTAL) || (srcNow == SRC_XTAL_PLL);
		clkLong = hasPll || hasXtal;
		// reset delay chain
		case (st_r.rst)
			ST_POR: begin
				if (st_r.rcnt >= CNT_W'(PORC - 1)) begin
					st_nxt.rst = ST_START;
					st_nxt.rcnt = '0;
				end else begin
					st_nxt.rcnt = st_r.rcnt + 1'b1;
				end
			end
			ST_START: begin
				// long timer only without the regulator
				if (st_r.rcnt >= (regulatorEn ? CNT_W'(STARTC - 1) :
						CNT_W'(PWRTC - 1))) begin
					st_nxt.rst = ST_RST;
					st_nxt.rcnt = '0;
				end else begin
					st_nxt.rcnt = st_r.rcnt + 1'b1;
				end
			end
			ST_RST: begin
				if (st_r.rcnt >= CNT_W'(RSTC - 1)) begin
					st_nxt.rst = ST_DONE;
					st_nxt.rcnt = '0;
				end else begin
					st_nxt.rcnt = st_r.rcnt + 1'b1;
				end
			end
			default: begin
				st_nxt.rcnt = '0;
			end
		endcase
		// clock qualification, independent of the reset chain
		case (st_r.ck)
			CK_OST: begin
				if (!hasXtal) begin
					st_nxt.ck = hasPll ? CK_LOCK : CK_OK;
				end else if (oscTick) begin
					st_nxt.ost = st_r.ost + 1'b1;
					if (st_r.ost == '1) begin
						st_nxt.ck = hasPll ? CK_LOCK : CK_OK;
					end
				end
			end
			CK_LOCK: begin
				// lock must hold for the whole interval
				if (!pllLocked) begin
					st_nxt.kcnt = '0;
				end else if (st_r.kcnt >= CNT_W'(LOCKC - 1)) begin
					st_nxt.ck = CK_OK;
				end else begin
					st_nxt.kcnt = st_r.kcnt + 1'b1;
				end
			end
			default: begin
			end
		endcase
		// monitor delay begins after the power-on and start-up delays
		if (st_r.monWait && (st_r.rst == ST_RST || st_r.rst == ST_DONE)) begin
			if (st_r.mcnt >= CNT_W'(MONC - 1)) begin
				st_nxt.monWait = 1'b0;
			end else begin
				st_nxt.mcnt = st_r.mcnt + 1'b1;
			end
		end
		if (monitorEn && st_r.rst == ST_DONE && !st_r.monWait &&
				!st_r.monOn) begin
			st_nxt.monOn = 1'b1;
			evSet[EV_MONON] = 1'b1;
			if (!clockValid) begin
				st_nxt.fastRc = 1'b1;
				st_nxt.trap = 1'b1;
				st_nxt.src = SRC_FRC;
				st_nxt.ck = CK_OK;
				evSet[EV_CLKFAIL] = 1'b1;
			end
		end
		if (st_r.trap && st_r.runQ) begin
			st_nxt.trap = 1'b0;
		end
		st_nxt.runQ = (st_r.rst == ST_DONE) && (st_r.ck == CK_OK);
		if (st_nxt.runQ && !st_r.runQ) begin
			evSet[EV_RUN] = 1'b1;
		end
		// warm resets and wake
		if (|warmReq) begin
			st_nxt.rst = ST_RST;
			st_nxt.rcnt = '0;
			st_nxt.runQ = 1'b0;
			st_nxt.monOn = 1'b0;
			st_nxt.trap = 1'b0;
			st_nxt.cause = st_r.cause | warmReq;
			st_nxt.fastRc = 1'b0;
			st_nxt.src = rcss_src_e'(oscConfigWord);
		end else if (wakeReq && regulatorEn && st_r.rst == ST_DONE) begin
			st_nxt.rst = ST_START;
			st_nxt.rcnt = '0;
			st_nxt.runQ = 1'b0;
		end
		// register port; event and mask bits survive warm resets, only power-on clears them
		st_nxt.rdata = '0;
		if (regRd) begin
			if (regAddr == ADDR_CAUSE) begin
				st_nxt.rdata = 16'(st_r.cause);
			end else if (regAddr == ADDR_OSC) begin
				st_nxt.rdata = {12'h000, st_r.fastRc, st_r.src};
			end else if (regAddr == ADDR_STAT) begin
				st_nxt.rdata = {10'h000, st_r.ck, st_r.monWait, st_r.monOn,
					st_r.runQ, st_r.trap};
			end else if (regAddr == ADDR_IRQ) begin
				st_nxt.rdata = 16'(st_r.evt);
			end else if (regAddr == ADDR_MASK) begin
				st_nxt.rdata = 16'(st_r.mask);
			end
		end
		if (regWr) begin
			if (regAddr == ADDR_CAUSE) begin
				// a warm request in the same cycle as the clear wins
				st_nxt.cause = (st_nxt.cause & ~regWdata[CAUSE_W-1:0]) |
					warmReq;
			end else if (regAddr == ADDR_IRQ) begin
				st_nxt.evt = st_r.evt & ~regWdata[EV_W-1:0];
			end else if (regAddr == ADDR_MASK) begin
				st_nxt.mask = regWdata[EV_W-1:0];
			end else if (regAddr == ADDR_CTRL && regWdata[0]) begin
				// software leaves the fast rc fallback
				st_nxt.fastRc = 1'b0;
				st_nxt.src = rcss_src_e'(regWdata[3:1]);
				st_nxt.ck = CK_OST;
				st_nxt.ost = '0;
				st_nxt.kcnt = '0;
			end
		end
		// set wins over a clear in the same cycle
		st_nxt.evt = st_nxt.evt | evSet;
		if (!clkLong) begin
			st_nxt.monWait = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			st_r <= ST_INIT;
			cfgTaken_r <= 1'b0;
		end else begin
			cfgTaken_r <= 1'b1;
			st_r <= st_nxt;
		end
	end

	assign regRdata = st_r.rdata;
	assign systemResetSignal = (st_r.rst != ST_DONE);
	assign coreRun = st_r.runQ;
	assign monitorActive = st_r.monOn;
	assign useFastRc = st_r.fastRc;
	assign trapReq = st_r.trap;
	assign irq = |(st_r.evt & st_r.mask);

endmodule
`default_nettype wire

// ### verif/rcss_props.sv
/*
 port assertions for the sequencer, bound into every instance.
 assumes the short delay parameters of the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module rcss_props
	import rcss_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic extResetPinReq,
	input wire logic watchdogReq,
	input wire logic [3:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [15:0] regRdata,
	input wire logic systemResetSignal,
	input wire logic coreRun,
	input wire logic monitorActive,
	input wire logic useFastRc,
	input wire logic trapReq,
	input wire logic irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	logic warm;
	assign warm = extResetPinReq || watchdogReq;
	AST_POR_HOLD: assert property (
		$fell(reset) |-> systemResetSignal[*8])
		else $error("released early after power-on");
	AST_WARM_HOLD: assert property (warm |-> ##[1:2] systemResetSignal)
		else $error("warm request did not hold reset");
	AST_WARM_LEN: assert property (
		$fell(warm) |-> ##1 systemResetSignal[*8])
		else $error("internal reset time too short");
	AST_RUN_CLEAN: assert property ($rose(coreRun) |-> !systemResetSignal)
		else $error("core runs under reset");
	AST_MON_REL: assert property (
		$rose(monitorActive) |-> !systemResetSignal)
		else $error("monitor started under reset");
	AST_TRAP_FRC: assert property ($rose(trapReq) |-> ##[0:1] useFastRc)
		else $error("trap without fast rc");
	AST_UNMAPPED: assert property (
		regRd && regAddr > ADDR_CTRL |=> regRdata == 16'h0)
		else $error("unmapped read not zero");
	AST_IRQ_MASK: assert property (
		regWr && regAddr == ADDR_MASK && regWdata[2:0] == 3'h0 |-> ##2 !irq)
		else $error("irq high with all masked");
	COV_RUN: cover property ($rose(coreRun));
	COV_TRAP: cover property ($rose(trapReq));
	COV_MON: cover property ($rose(monitorActive));
endmodule
////////////////////////////////////////////////////////////////////////////////
bind rcss_sequencer rcss_props rcss_props_inst (.*);
`default_nettype wire

// ### verif/rcss_osc_model.sv
/*
 oscillator and pll model: one tick every other cycle while started,
 lock LOCKDLY cycles after start. assumes start comes from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module rcss_osc_model #(parameter int LOCKDLY = 30) (
	input wire logic mclk,
	input wire logic start,
	output logic oscTick,
	output logic pllLocked
);
	int n = 0;
	// stopped oscillator stands still, no ticks and no lock
	always_ff @(posedge mclk) begin
		n <= start ? n + 1 : 0;
		oscTick <= start && !oscTick;
		pllLocked <= start && n >= LOCKDLY;
	end
endmodule
`default_nettype wire

// ### verif/test_reset_clock_startup_sequencer.sv
/*
 bench: power-on for five of the seven clock sources, warm resets, registers, interrupt.
 assumes the shortened delay parameters set below.
*/
`timescale 1ns/1ps
`default_nettype none
module test_reset_clock_startup_sequencer
	import rcss_pkg::*;
;
	localparam int P = 5;
	localparam int S = 10;
	localparam int W = 50;
	localparam int R = 10;
	localparam int L = 10;
	localparam int X = 2048 - P - S - R; // ticks start at release of reset
	logic reset = 1'b1, wakeReq = 1'b0, regulatorEn = 1'b1, oscOn = 1'b0;
	logic monitorEn = 1'b1, clockValid = 1'b1, regWr = 1'b0, regRd = 1'b0;
	logic mclk, oscTick, pllLocked, irq, coreRun, monitorActive;
	logic systemResetSignal, useFastRc, trapReq;
	logic [5:0] warmReq = 6'h0;
	logic [2:0] oscConfigWord = 3'h0;
	logic [3:0] regAddr = 4'h0;
	logic [15:0] regWdata = 16'h0, regRdata, d;
	int fail_count = 0, comparisons = 0, n;
	rcss_sequencer #(.PORC(P), .STARTC(S), .PWRTC(W), .RSTC(R),
		.LOCKC(L), .MONC(20)) rcss_sequencer_inst (.*,
		.extResetPinReq(warmReq[0]), .watchdogReq(warmReq[1]),
		.softwareReq(warmReq[2]), .illegalOpcodeReq(warmReq[3]),
		.uninitRegReq(warmReq[4]), .trapConflictReq(warmReq[5]));
	rcss_osc_model #(.LOCKDLY(30)) rcss_osc_model_inst (.mclk(mclk),
		.start(oscOn), .oscTick(oscTick), .pllLocked(pllLocked));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic inRange(input int lo, input int hi);
		check({15'h0, n >= lo && n <= hi}, 16'h1);
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		regAddr <= a;
		regWdata <= v;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		@(posedge mclk);
		v = regRdata;
	endtask
	// bounded wait, counts edges in n
	task automatic waitSig(ref logic s, input logic v);
		n = 0;
		while (s !== v && n < 5000) begin
			@(posedge mclk);
			n++;
		end
		if (n == 5000) begin
			fail_count++;
			end_of_test();
		end
	endtask
	task automatic por(input logic [2:0] src, input logic rg, on);
		oscConfigWord <= src;
		regulatorEn <= rg;
		reset <= 1'b1;
		oscOn <= 1'b0;
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		oscOn <= on;
		waitSig(systemResetSignal, 1'b0);
	endtask
	task automatic end_of_test();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		@(posedge mclk);
		por(SRC_EXT, 1'b1, 1'b0);
		inRange(P + S + R - 2, P + S + R + 3);
		waitSig(monitorActive, 1'b1);
		inRange(0, 3);
		waitSig(coreRun, 1'b1);
		inRange(0, 3);
		rd(ADDR_CAUSE, d);
		check(d, 16'h1);
		wr(ADDR_MASK, 16'h1);
		@(posedge mclk);
		check({15'h0, irq}, 16'h1);
		wr(ADDR_IRQ, 16'h7);
		@(posedge mclk);
		check({15'h0, irq}, 16'h0);
		wr(ADDR_MASK, 16'h0);
		rd(4'hf, d);
		check(d, 16'h0);
		for (int i = 0; i < 6; i++) begin
			wr(ADDR_CAUSE, 16'h7f);
			warmReq[i] <= 1'b1;
			@(posedge mclk);
			warmReq <= 6'h0;
			@(posedge mclk);
			check({15'h0, systemResetSignal}, 16'h1);
			waitSig(systemResetSignal, 1'b0);
			inRange(R - 3, R + 2);
			waitSig(coreRun, 1'b1);
			rd(ADDR_CAUSE, d);
			check(d, 16'h1 << (i + 1));
		end
		por(SRC_FRC, 1'b0, 1'b0);
		inRange(P + W + R - 2, P + W + R + 3);
		por(SRC_XTAL, 1'b1, 1'b1);
		check({14'h0, coreRun, monitorActive}, 16'h0);
		waitSig(coreRun, 1'b1);
		inRange(X - 3, X + 4);
		por(SRC_XTAL_PLL, 1'b1, 1'b1);
		waitSig(coreRun, 1'b1);
		inRange(X + L - 3, X + L + 6);
		por(SRC_EXT_PLL, 1'b1, 1'b1);
		waitSig(coreRun, 1'b1);
		inRange(12, 21);
		clockValid <= 1'b0;
		por(SRC_XTAL, 1'b1, 1'b0);
		waitSig(trapReq, 1'b1);
		inRange(7, 16);
		check({15'h0, useFastRc}, 16'h1);
		wr(ADDR_MASK, 16'h2);
		@(posedge mclk);
		check({15'h0, irq}, 16'h1);
		wr(ADDR_CTRL, 16'h1);
		rd(ADDR_OSC, d);
		check(d, 16'h0);
		wakeReq <= 1'b1;
		@(posedge mclk);
		wakeReq <= 1'b0;
		@(posedge mclk);
		check({15'h0, systemResetSignal}, 16'h1);
		waitSig(systemResetSignal, 1'b0);
		inRange(S + R - 3, S + R + 2);
		end_of_test();
	end
endmodule
`default_nettype wire
